// ### rtl/hmcr_device.sv
// Overview of operation
// R1 - Read of offset 0BH returns mode register
// R2 - Write 0BH updates only right after read
// R3 - Otherwise write 0BH goes to byte count
// R4 - Bits 0-1 select media type
// R5 - Twisted pair modes use twisted-pair lines
// R6 - Coax type pin: thick low, thin high
// R7 - Reduced squelch mode lowers receive thresholds
// R8 - Bit 2 one disables link pulses, checks
// R9 - Link status reads 0: coax or bad
// R10 - Link status reads 1: good or disabled
// R11 - Bit 3 delays wide indication to strobe
// R12 - Software keeps reserved bit 4 zero
// R13 - Bus error set on ignored wait states
// R14 - Writing one clears bus error flag
// R15 - Bit 6 low blocks boot memory writes
// R16 - Writing one to bit 7 starts reload
// R17 - Bit 7 never high from straps
// R18 - No read-modify-write of this register
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module hmcr_device (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  hmcr_link_if.dev link,
  input wire logic link_good_in,
  input wire logic insert_wait_in,
  input wire logic boot_wr_req_in,
  output logic twisted_pair_port_out,
  output logic coax_thin_out,
  output logic reduced_squelch_out,
  output logic link_test_off_out,
  output logic link_led_out,
  output logic boot_wr_out,
  output logic eeprom_reload_out,
  output logic [7:0] remote_count_hi_out
);
  import hmcr_pkg::*;

  logic [1:0] media_select_reg;
  logic link_check_off_reg;
  logic wide_cycle_signal_timing_reg;
  logic rsvd_reg;
  logic wait_violation_flag_reg;
  logic boot_rom_write_allow_reg;
  logic unlock_reg;
  logic rd_d_reg;
  logic wr_d_reg;
  logic violation;
  logic rd_rise;
  logic wr_rise;
  logic hit_cfg;
  logic cfg_wr;
  logic link_status;
  logic media_tp;
  logic [7:0] cfg_read;

  // Decoding used for link status reads and pin drive
  function automatic logic is_tp(input logic [1:0] sel);
    return (sel == HMCR_MEDIA_TP_STD) || (sel == HMCR_MEDIA_TP_LOW);
  endfunction : is_tp

  assign rd_rise = link.io_rd && !rd_d_reg;
  assign wr_rise = link.io_wr && !wr_d_reg;
  assign hit_cfg = link.cyc_sel && (link.bus_addr == HMCR_OFS_MODE_CFG);
  assign cfg_wr = wr_rise && hit_cfg && unlock_reg; // [R2]
  assign media_tp = is_tp(media_select_reg);
  // LED follows this status: coax forces 0, otherwise disabled forces 1
  assign link_status = media_tp
      && (link_check_off_reg || link_good_in); // [R9] [R10]

  // Bit 7 always reads 0: the reload trigger does not hold
  always_comb begin
    cfg_read = HMCR_RST_BYTE;
    cfg_read[HMCR_B_MEDIA_HI:HMCR_B_MEDIA_LO] = media_select_reg;
    cfg_read[HMCR_B_LINK] = link_status; // [R9] [R10]
    cfg_read[HMCR_B_WIDE] = wide_cycle_signal_timing_reg;
    cfg_read[HMCR_B_RSVD] = rsvd_reg;
    cfg_read[HMCR_B_WAITV] = wait_violation_flag_reg;
    cfg_read[HMCR_B_BOOTW] = boot_rom_write_allow_reg;
  end

  // Strobe history for one action per access
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_d_reg <= 1'b0;
      wr_d_reg <= 1'b0;
    end else begin
      rd_d_reg <= link.io_rd;
      wr_d_reg <= link.io_wr;
    end
  end

  // Unlock armed by a read of 0BH, lost on any other access
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      unlock_reg <= 1'b0;
    end else if (rd_rise && link.cyc_sel) begin
      unlock_reg <= hit_cfg; // [R2] [R3]
    end else if (wr_rise && link.cyc_sel) begin
      unlock_reg <= 1'b0; // [R3]
    end
  end

  // Plain register fields, written only when unlocked
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      media_select_reg <= HMCR_RST_MEDIA;
      link_check_off_reg <= HMCR_RST_BIT;
      wide_cycle_signal_timing_reg <= HMCR_RST_BIT;
      rsvd_reg <= HMCR_RST_BIT;
      boot_rom_write_allow_reg <= HMCR_RST_BIT;
    end else if (cfg_wr) begin
      media_select_reg <=
          link.bus_wdata[HMCR_B_MEDIA_HI:HMCR_B_MEDIA_LO]; // [R4]
      link_check_off_reg <= link.bus_wdata[HMCR_B_LINK]; // [R8]
      wide_cycle_signal_timing_reg <= link.bus_wdata[HMCR_B_WIDE];
      // Stored as written; software is expected to keep it 0
      rsvd_reg <= link.bus_wdata[HMCR_B_RSVD]; // [R12]
      boot_rom_write_allow_reg <= link.bus_wdata[HMCR_B_BOOTW];
    end
  end

  // Locked write at 0BH lands in the upper byte count
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      remote_count_hi_out <= HMCR_RST_BYTE;
    end else if (wr_rise && hit_cfg && !unlock_reg) begin
      remote_count_hi_out <= link.bus_wdata; // [R3]
    end
  end

  // Sticky bus error; a new violation beats a same-cycle clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_violation_flag_reg <= HMCR_RST_BIT;
    end else if (violation) begin
      wait_violation_flag_reg <= 1'b1; // [R13]
    end else if (cfg_wr && link.bus_wdata[HMCR_B_WAITV]) begin
      wait_violation_flag_reg <= 1'b0; // [R14]
    end
  end

  // Reload trigger is a one-cycle pulse, never a stored level
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eeprom_reload_out <= 1'b0;
    end else begin
      eeprom_reload_out <= cfg_wr
          && link.bus_wdata[HMCR_B_EEPROM_RELOAD_TRIGGER]; // [R16] [R17]
    end
  end

  // Wait request only once a strobe is active
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.chan_rdy <= 1'b1;
    end else begin
      link.chan_rdy <= !((link.io_rd || link.io_wr) && insert_wait_in);
    end
  end

  hmcr_wait_mon u_wait_mon (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .strobe_in(link.io_rd || link.io_wr),
    .wait_req_in(!link.chan_rdy),
    .violation_out(violation)
  ); // [R13]

  // Read data; other page-0 offsets are outside this block
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.bus_rdata <= HMCR_RST_BYTE;
    end else if (hit_cfg) begin
      link.bus_rdata <= cfg_read; // [R1]
    end else begin
      link.bus_rdata <= HMCR_RST_BYTE;
    end
  end

  // Wide cycle: on decode alone, or delayed to the strobe
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.wide_cycle <= 1'b0;
    end else if (wide_cycle_signal_timing_reg) begin
      link.wide_cycle <= link.cyc_sel
          && (link.io_rd || link.io_wr); // [R11]
    end else begin
      link.wide_cycle <= link.cyc_sel; // [R11]
    end
  end

  // Media pins; thick coax drives the converter enable low
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      twisted_pair_port_out <= 1'b0;
      coax_thin_out <= 1'b0;
      reduced_squelch_out <= 1'b0;
    end else begin
      twisted_pair_port_out <= media_tp; // [R5]
      coax_thin_out <= (media_select_reg == HMCR_MEDIA_THIN); // [R6]
      reduced_squelch_out <=
          (media_select_reg == HMCR_MEDIA_TP_LOW); // [R7]
    end
  end

  // Link test control, LED and boot memory write gate
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_test_off_out <= 1'b0;
      link_led_out <= 1'b0;
      boot_wr_out <= 1'b0;
    end else begin
      link_test_off_out <= link_check_off_reg; // [R8]
      link_led_out <= link_status; // [R9] [R10]
      boot_wr_out <= boot_wr_req_in
          && boot_rom_write_allow_reg; // [R15]
    end
  end
endmodule : hmcr_device

// ### rtl/hmcr_pkg.sv
package hmcr_pkg;
  // Link side: page-0 offsets
  localparam logic [3:0] HMCR_OFS_MODE_CFG = 4'h0_00B;
  localparam logic [3:0] HMCR_OFS_NONE = 4'h0_000;
  // Mode configuration field positions
  localparam int HMCR_B_MEDIA_LO = 0;
  localparam int HMCR_B_MEDIA_HI = 1;
  localparam int HMCR_B_LINK = 2;
  localparam int HMCR_B_WIDE = 3;
  localparam int HMCR_B_RSVD = 4;
  localparam int HMCR_B_WAITV = 5;
  localparam int HMCR_B_BOOTW = 6;
  localparam int HMCR_B_EEPROM_RELOAD_TRIGGER = 7;
  // Media select codes
  localparam logic [1:0] HMCR_MEDIA_TP_STD = 2'h0_000;
  localparam logic [1:0] HMCR_MEDIA_THIN = 2'h0_001;
  localparam logic [1:0] HMCR_MEDIA_THICK = 2'h0_002;
  localparam logic [1:0] HMCR_MEDIA_TP_LOW = 2'h0_003;
  // Reset values
  localparam logic [1:0] HMCR_RST_MEDIA = 2'h0_000;
  localparam logic HMCR_RST_BIT = 1'b0;
  localparam logic [7:0] HMCR_RST_BYTE = 8'h0_000;
  // Host controller register offsets and fields
  localparam logic [2:0] HMCR_H_CTRL = 3'h0_000;
  localparam logic [2:0] HMCR_H_WDATA = 3'h0_001;
  localparam logic [2:0] HMCR_H_RDATA = 3'h0_002;
  localparam logic [2:0] HMCR_H_STAT = 3'h0_003;
  localparam logic [2:0] HMCR_H_MASK = 3'h0_004;
  localparam int HMCR_C_WRITE = 4;
  localparam int HMCR_C_NOWAIT = 5;
  localparam int HMCR_S_BUSY = 0;
  localparam int HMCR_S_DONE = 1;
  localparam int HMCR_S_WAIT = 2;
  localparam int HMCR_S_TOUT = 3;
  localparam int HMCR_MAX_WAIT = 255;
  // Host link sequencer states
  typedef enum logic [4:0] {
    HMCR_IDLE = 5'b00001,
    HMCR_SETUP = 5'b00010,
    HMCR_STRB = 5'b00100,
    HMCR_HOLD = 5'b01000,
    HMCR_END = 5'b10000
  } hmcr_hstate_t;
endpackage : hmcr_pkg

// ### rtl/hmcr_link_if.sv
`timescale 1ns/1ps
interface hmcr_link_if;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata;
  logic cyc_sel;
  logic io_rd;
  logic io_wr;
  logic [7:0] bus_rdata;
  logic chan_rdy;
  logic wide_cycle;
  modport dev (
    input bus_addr, bus_wdata, cyc_sel, io_rd, io_wr,
    output bus_rdata, chan_rdy, wide_cycle
  );
  modport host (
    output bus_addr, bus_wdata, cyc_sel, io_rd, io_wr,
    input bus_rdata, chan_rdy, wide_cycle
  );
endinterface : hmcr_link_if

// ### rtl/hmcr_wait_mon.sv
`timescale 1ns/1ps
module hmcr_wait_mon (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic strobe_in,
  input wire logic wait_req_in,
  output logic violation_out
);
  logic strobe_d_reg;

  // Previous strobe level for fall detection
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= strobe_in;
    end
  end

  // Strobe ended while wait was still requested: cycle cut short
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      violation_out <= 1'b0;
    end else begin
      violation_out <= strobe_d_reg && !strobe_in && wait_req_in;
    end
  end
endmodule : hmcr_wait_mon

// ### rtl/hmcr_host.sv
`timescale 1ns/1ps
module hmcr_host #(
  parameter int MAX_WAIT = hmcr_pkg::HMCR_MAX_WAIT
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  hmcr_link_if.host link,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_out
);
  import hmcr_pkg::*;

  localparam int CW = $clog2(MAX_WAIT + 1);

  hmcr_hstate_t state_reg;
  hmcr_hstate_t state_next;
  logic [5:0] ctrl_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic [3:0] stat_reg;
  logic [3:0] mask_reg;
  logic [CW-1:0] wait_cnt_reg;
  logic start;
  logic timeout;
  logic released;
  logic [3:0] set_ev;

  // Counter must reach at least one wait cycle
  if (MAX_WAIT < 1) begin : g_bad_wait
    $error("MAX_WAIT must be at least 1");
  end

  assign start = reg_wr_in && (reg_addr_in == HMCR_H_CTRL);
  assign timeout = (wait_cnt_reg == CW'(MAX_WAIT));
  // Ignoring waits is how a cut-short cycle is produced on purpose
  assign released = link.chan_rdy || ctrl_reg[HMCR_C_NOWAIT] || timeout;

  // Access sequencer: setup, strobe, hold for ready, end
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HMCR_IDLE: if (start) state_next = HMCR_SETUP;
      HMCR_SETUP: state_next = HMCR_STRB;
      HMCR_STRB: state_next = HMCR_HOLD;
      HMCR_HOLD: if (released) state_next = HMCR_END;
      HMCR_END: state_next = HMCR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= HMCR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Cycles spent waiting for ready
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_cnt_reg <= '0;
    end else if (state_reg != HMCR_HOLD) begin
      wait_cnt_reg <= '0;
    end else if (!timeout) begin
      wait_cnt_reg <= wait_cnt_reg + CW'(1);
    end
  end

  // Link drive straight from flops, from the next state
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link.cyc_sel <= 1'b0;
      link.io_rd <= 1'b0;
      link.io_wr <= 1'b0;
      link.bus_addr <= HMCR_OFS_NONE;
      link.bus_wdata <= HMCR_RST_BYTE;
    end else begin
      link.cyc_sel <= (state_next != HMCR_IDLE);
      link.io_rd <= ((state_next == HMCR_STRB)
          || (state_next == HMCR_HOLD)) && !ctrl_reg[HMCR_C_WRITE];
      link.io_wr <= ((state_next == HMCR_STRB)
          || (state_next == HMCR_HOLD)) && ctrl_reg[HMCR_C_WRITE];
      if (start && state_reg == HMCR_IDLE) begin
        link.bus_addr <= reg_wdata_in[3:0];
        link.bus_wdata <= wdata_reg;
      end
    end
  end

  // Command and data; a start while busy is ignored
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg <= '0;
      wdata_reg <= HMCR_RST_BYTE;
      mask_reg <= '0;
    end else if (reg_wr_in) begin
      if (start && state_reg == HMCR_IDLE) ctrl_reg <= reg_wdata_in[5:0];
      if (reg_addr_in == HMCR_H_WDATA) wdata_reg <= reg_wdata_in;
      if (reg_addr_in == HMCR_H_MASK) mask_reg <= reg_wdata_in[3:0];
    end
  end

  // Read data captured at the end of the strobe
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= HMCR_RST_BYTE;
    end else if (state_reg == HMCR_HOLD && released
        && !ctrl_reg[HMCR_C_WRITE]) begin
      rdata_reg <= link.bus_rdata;
    end
  end

  // Sticky events, write one to clear, set wins
  always_comb begin
    set_ev = '0;
    set_ev[HMCR_S_DONE] = (state_reg == HMCR_END);
    set_ev[HMCR_S_WAIT] = (state_reg == HMCR_HOLD) && !link.chan_rdy;
    set_ev[HMCR_S_TOUT] = (state_reg == HMCR_HOLD) && timeout;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stat_reg <= '0;
    end else if (reg_wr_in && reg_addr_in == HMCR_H_STAT) begin
      stat_reg <= (stat_reg & ~reg_wdata_in[3:0]) | set_ev;
    end else begin
      stat_reg <= stat_reg | set_ev;
    end
  end

  // Level interrupt; busy bit is live and never interrupts
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(stat_reg & mask_reg & 4'b1110);
    end
  end

  // Register read port, data in the following cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= HMCR_RST_BYTE;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        HMCR_H_CTRL: reg_rdata_out <= {2'b00, ctrl_reg};
        HMCR_H_WDATA: reg_rdata_out <= wdata_reg;
        HMCR_H_RDATA: reg_rdata_out <= rdata_reg;
        HMCR_H_STAT: reg_rdata_out <= {4'h0_000,
            stat_reg[3:1], state_reg != HMCR_IDLE};
        HMCR_H_MASK: reg_rdata_out <= {4'h0_000, mask_reg};
        default: reg_rdata_out <= HMCR_RST_BYTE;
      endcase
    end
  end
endmodule : hmcr_host

// ### verif/hmcr_checker.sv
`timescale 1ns/1ps
module hmcr_checker (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic cyc_sel,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] bus_rdata,
  input wire logic chan_rdy,
  input wire logic wide_cycle
);
  import hmcr_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // Strobe holds at least two cycles once the cycle opens
  sequence strobe_held;
    (io_rd || io_wr) [*2];
  endsequence
  sequence strobe_drop;
    $fell(io_rd || io_wr);
  endsequence
  a_strobe_after_sel: assert property (
    $rose(cyc_sel) |=> strobe_held) else $error("strobe late");
  a_strobe_exclusive: assert property (
    !(io_rd && io_wr)) else $error("both strobes high");
  a_strobe_in_sel: assert property (
    (io_rd || io_wr) |-> cyc_sel) else $error("strobe outside cycle");
  a_addr_stable: assert property (
    cyc_sel && $past(cyc_sel) |-> $stable(bus_addr))
    else $error("address moved in cycle");
  a_wdata_stable: assert property (
    io_wr && $past(io_wr) |-> $stable(bus_wdata))
    else $error("write data moved");
  a_cycle_closes: assert property (
    strobe_drop |-> ##[0:1] !cyc_sel) else $error("cycle left open");
  // Only the hidden offset may return nonzero data
  a_rdata_other_zero: assert property (
    !$past(cyc_sel && bus_addr == HMCR_OFS_MODE_CFG) |-> bus_rdata == 8'h00)
    else $error("data on other offset");
  // Both timing modes raise the indication once a strobe is seen
  a_wide_on_strobe: assert property (
    $past(cyc_sel && (io_rd || io_wr)) |-> wide_cycle)
    else $error("wide indication missing");
  a_wide_needs_sel: assert property (
    wide_cycle |-> $past(cyc_sel)) else $error("wide without decode");
  a_wait_after_strobe: assert property (
    !chan_rdy |-> $past(io_rd || io_wr)) else $error("wait without strobe");
endmodule : hmcr_checker

// ### verif/hidden_mode_config_register_test.sv
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("BAD %s exp=%h got=%h", name, exp, got); end end
module hidden_mode_config_register_test;
  import hmcr_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic link_good = 1'b0;
  logic insert_wait = 1'b0;
  logic boot_req = 1'b0;
  logic [7:0] reg_rdata, count_hi;
  logic irq, tp_port, coax_thin, low_sq, test_off, led, boot_wr, reload;
  int errors = 0;
  int checked = 0;
  int reloads = 0;
  int wides = 0;
  hmcr_link_if lnk();
  hmcr_device hmcr_device_i (.ref_clk_in(ref_clk), .rstn_in(rstn),
    .link(lnk), .link_good_in(link_good), .insert_wait_in(insert_wait),
    .boot_wr_req_in(boot_req), .twisted_pair_port_out(tp_port),
    .coax_thin_out(coax_thin), .reduced_squelch_out(low_sq),
    .link_test_off_out(test_off), .link_led_out(led),
    .boot_wr_out(boot_wr), .eeprom_reload_out(reload),
    .remote_count_hi_out(count_hi));
  // Short wait limit keeps stalled cycles brief
  hmcr_host #(.MAX_WAIT(4)) hmcr_host_i (.ref_clk_in(ref_clk),
    .rstn_in(rstn), .link(lnk), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .irq_out(irq));
  hmcr_checker hmcr_checker_i (.ref_clk_in(ref_clk), .rstn_in(rstn),
    .bus_addr(lnk.bus_addr), .bus_wdata(lnk.bus_wdata),
    .cyc_sel(lnk.cyc_sel), .io_rd(lnk.io_rd), .io_wr(lnk.io_wr),
    .bus_rdata(lnk.bus_rdata), .chan_rdy(lnk.chan_rdy),
    .wide_cycle(lnk.wide_cycle));
  always #2 ref_clk = ~ref_clk;
  // Count reload pulses; each must be a single cycle
  always @(posedge ref_clk) begin
    if (reload === 1'b1) begin
      reloads++;
    end
  end
  // Cycles with the wide indication up; tells the two timings apart
  always @(posedge ref_clk) begin
    if (lnk.wide_cycle === 1'b1) begin
      wides++;
    end
  end
  task automatic reg_wr_t(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t
  // Data is sampled in the one cycle after the strobe
  task automatic reg_rd_t(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd_t
  // One link cycle; done cleared first so a stale flag cannot fool us
  task automatic link_acc(input logic w, input logic nw, input logic [3:0] o,
      input logic [7:0] d, output logic [7:0] q, output logic [7:0] st);
    int n;
    reg_wr_t(HMCR_H_STAT, 8'h0E);
    reg_wr_t(HMCR_H_WDATA, d);
    reg_wr_t(HMCR_H_CTRL, {2'b00, nw, w, o});
    n = 0;
    st = 8'h00;
    while (st[HMCR_S_DONE] !== 1'b1 && n < 40) begin
      reg_rd_t(HMCR_H_STAT, st);
      n++;
    end
    `CHK("done", 1'b1, st[HMCR_S_DONE])
    reg_rd_t(HMCR_H_RDATA, q);
  endtask : link_acc
  task automatic rd_b(output logic [7:0] q);
    logic [7:0] st;
    link_acc(1'b0, 1'b0, HMCR_OFS_MODE_CFG, 8'h00, q, st);
  endtask : rd_b
  // Whole-byte write after unlock, reserved bit low
  task automatic wr_b(input logic [7:0] d);
    logic [7:0] q, st;
    rd_b(q);
    link_acc(1'b1, 1'b0, HMCR_OFS_MODE_CFG, d, q, st);
  endtask : wr_b
  task automatic t_media;
    logic [7:0] q;
    rd_b(q);
    `CHK("mode_rst", 8'h00, q)
    for (int m = 0; m < 4; m++) begin
      wr_b({6'h00, m[1:0]});
      rd_b(q);
      `CHK("media", m[1:0], q[1:0])
      `CHK("tp_port", m == 0 || m == 3, tp_port)
      `CHK("thin", m == 1, coax_thin)
      `CHK("low_sq", m == 3, low_sq)
    end
  endtask : t_media
  task automatic t_lock;
    logic [7:0] q, st;
    wr_b(8'h01);
    rd_b(q);
    link_acc(1'b0, 1'b0, 4'h0, 8'h00, q, st);
    link_acc(1'b1, 1'b0, 4'hB, 8'hA6, q, st);
    `CHK("count_hi", 8'hA6, count_hi)
    link_acc(1'b1, 1'b0, 4'hB, 8'h5B, q, st);
    `CHK("count_hi2", 8'h5B, count_hi)
    rd_b(q);
    `CHK("mode_kept", 2'b01, q[1:0])
  endtask : t_lock
  // Table of {link good, expected status, written byte}
  task automatic t_link;
    logic [7:0] q;
    logic [9:0] tbl [4] = '{10'h000, 10'h300, 10'h104, 10'h202};
    foreach (tbl[i]) begin
      @(posedge ref_clk);
      link_good <= tbl[i][9];
      wr_b(tbl[i][7:0]);
      rd_b(q);
      `CHK("link_bit", tbl[i][8], q[HMCR_B_LINK])
      `CHK("led", tbl[i][8], led)
      `CHK("test_off", tbl[i][2], test_off)
    end
  endtask : t_link
  task automatic t_buserr;
    logic [7:0] q, st;
    wr_b(8'h00);
    @(posedge ref_clk);
    insert_wait <= 1'b1;
    link_acc(1'b0, 1'b1, 4'h0, 8'h00, q, st);
    `CHK("wait_seen", 1'b1, st[HMCR_S_WAIT])
    @(posedge ref_clk);
    insert_wait <= 1'b0;
    rd_b(q);
    `CHK("err_set", 1'b1, q[HMCR_B_WAITV])
    wr_b(8'h00);
    rd_b(q);
    `CHK("err_kept", 1'b1, q[HMCR_B_WAITV])
    wr_b(8'h20);
    rd_b(q);
    `CHK("err_clr", 1'b0, q[HMCR_B_WAITV])
    // Waits honoured until the host gives up: cycle still cut short
    @(posedge ref_clk);
    insert_wait <= 1'b1;
    link_acc(1'b0, 1'b0, 4'h0, 8'h00, q, st);
    `CHK("tout_seen", 1'b1, st[HMCR_S_TOUT])
    @(posedge ref_clk);
    insert_wait <= 1'b0;
    rd_b(q);
    `CHK("err_tout", 1'b1, q[HMCR_B_WAITV])
    wr_b(8'h20);
    rd_b(q);
    `CHK("err_clr2", 1'b0, q[HMCR_B_WAITV])
  endtask : t_buserr
  task automatic t_boot;
    logic [7:0] q;
    int w0;
    @(posedge ref_clk);
    boot_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("boot_off", 1'b0, boot_wr)
    `CHK("no_reload", 0, reloads)
    // Decode timing: indication spans the whole open cycle
    w0 = wides;
    rd_b(q);
    `CHK("wide_decode", 4, wides - w0)
    wr_b(8'h48);
    `CHK("boot_on", 1'b1, boot_wr)
    wr_b(8'hC8);
    `CHK("reload", 1, reloads)
    // Strobe timing: indication only while a strobe was seen
    w0 = wides;
    rd_b(q);
    `CHK("wide_strobe", 2, wides - w0)
    `CHK("reload_bit", 8'h48, q & 8'hF8)
  endtask : t_boot
  task automatic t_irq;
    logic [7:0] q, st;
    reg_wr_t(HMCR_H_MASK, 8'h00);
    link_acc(1'b0, 1'b0, 4'h1, 8'h00, q, st);
    `CHK("irq_masked", 1'b0, irq)
    reg_wr_t(HMCR_H_MASK, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq_on", 1'b1, irq)
    reg_wr_t(HMCR_H_STAT, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq_off", 1'b0, irq)
    reg_rd_t(3'h7, q);
    `CHK("unmapped", 8'h00, q)
  endtask : t_irq
  task automatic tally_and_finish;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the fewer than one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_media();
    t_lock();
    t_link();
    t_buserr();
    t_boot();
    t_irq();
    tally_and_finish();
  end
endmodule : hidden_mode_config_register_test
